// File: hdl/sync_lock_map.vh
// Functional notes
// - Disregard bit set (reset) masks sync and sysref-request pins; clear uses them in phase-sync mode only.
// - High-hysteresis bit enables LVDS hysteresis on sync inputs; resets to zero.
// - Bias level: 0 Vin/4, 1 Vin, 2 Vin/2, 3 invalid; resets to zero.
// - Input format: 0 CMOS/CMOS, 1 LVDS/CMOS, 2 CMOS/LVDS, 3 LVDS/LVDS, 4-7 invalid.
// - Lock source 0 uses calibration only; 1 (reset) adds tuning-voltage check.
// - After calibration success wait holdoff phase-detector cycles, reset 1000, then lock.
// - Holdoff zero raises lock immediately when calibration succeeds.
// - Fractional phase sync: hold divider for 32-bit wait after modulator reset; reset 50000.
// - The wait adds directly to sync-to-output latency.
// - Modulator reset bit low holds modulator in reset and ignores fractions.
`ifndef SYNC_LOCK_MAP_VH
`define SYNC_LOCK_MAP_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_SYNC_PIN      7'h3a
`define IDX_LOCK_TYPE     7'h3b
`define IDX_LOCK_HOLDOFF  7'h3c
`define IDX_MOD_WAIT_HI   7'h45
`define IDX_MOD_WAIT_LO   7'h46
`define IDX_SYSREF_CTRL   7'h47
`define IDX_SYSREF_DIVIDER    7'h48
`define IDX_SYSREF_DLY_LO 7'h49
`define IDX_SYSREF_DLY_HI 7'h4a
`define IDX_IRQ_STATUS    7'h60
`define IDX_IRQ_MASK      7'h61
`define IDX_STATE         7'h62

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define BIT_PIN_DISREGARD 15
`define BIT_HYST          14
`define BIT_SRC           0
`define RST_SYNC_PIN      16'h8001
`define RST_LOCK_TYPE     16'h0001
`define RST_HOLDOFF       16'h03e8
`define RST_MOD_WAIT      32'h0000c350
`define RST_SYSREF_CTRL   16'h0081
`define RST_SYSREF_DIVIDER    16'h0000
`define RST_SYSREF_DLY_LO 16'h003f
`define RST_SYSREF_DLY_HI 16'h0000
`define IRQ_LOCK_RISE     0
`define IRQ_LOCK_FALL     1
`define IRQ_SYNC_DONE     2
`define IRQ_BAD_CODE      3

`endif

// File: hdl/sync_lock_detect_config.v
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`include "sync_lock_map.vh"

module sync_lock_detect_config (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        pd_tick,
  input  wire        cal_start,
  input  wire        cal_done,
  input  wire        vtune_ok,
  input  wire        phase_sync_mode,
  input  wire        modulator_reset_n,
  input  wire        sync_pin,
  input  wire        sysref_request_pin,
  output reg         lock_detect,
  output reg         modulator_hold,
  output reg         divider_hold,
  output wire        sync_gated,
  output wire        sysref_request_gated,
  output wire        input_high_hysteresis,
  output wire [1:0]  input_bias_level,
  output wire [2:0]  input_pin_format,
  output wire [15:0] sysref_control,
  output wire [15:0] sysref_divider,
  output wire [15:0] sysref_delay_low,
  output wire [15:0] sysref_delay_high_pulse_count,
  output wire        irq
);

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg [15:0] sync_input_pin_config;
  reg [15:0] lock_indicator_type;
  reg [15:0] lock_indicator_holdoff;
  reg [31:0] modulator_reset_wait;
  reg [15:0] sysref_ctrl_q;
  reg [15:0] sysref_divider_q;
  reg [15:0] sysref_dly_lo_q;
  reg [15:0] sysref_dly_hi_q;
  reg [3:0]  irq_status;
  reg [3:0]  irq_mask;

  wire [6:0] idx    = paddr[8:2];
  wire       access = psel & penable;
  wire       wr     = access & pwrite;
  wire       mapped = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0) && known(idx);

  function known;
    input [6:0] i;
    begin
      case (i)
        `IDX_SYNC_PIN, `IDX_LOCK_TYPE, `IDX_LOCK_HOLDOFF, `IDX_MOD_WAIT_HI,
        `IDX_MOD_WAIT_LO, `IDX_SYSREF_CTRL, `IDX_SYSREF_DIVIDER, `IDX_SYSREF_DLY_LO,
        `IDX_SYSREF_DLY_HI, `IDX_IRQ_STATUS, `IDX_IRQ_MASK, `IDX_STATE: known = 1'b1;
        default: known = 1'b0;
      endcase
    end
  endfunction

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  wire wr_ok = wr & mapped;

  // --------------------------------------------------------------------------
  // Sync pin gating and pin configuration
  // --------------------------------------------------------------------------
  wire disregard = sync_input_pin_config[`BIT_PIN_DISREGARD];
  wire pins_live = ~disregard & phase_sync_mode;
  assign sync_gated            = pins_live & sync_pin;
  assign sysref_request_gated  = pins_live & sysref_request_pin;
  assign input_high_hysteresis = sync_input_pin_config[`BIT_HYST];
  assign input_bias_level      = sync_input_pin_config[13:12];
  assign input_pin_format      = sync_input_pin_config[11:9];
  wire bad_code = (input_bias_level == 2'h3) | input_pin_format[2];

  assign sysref_control                = sysref_ctrl_q;
  assign sysref_divider                = sysref_divider_q;
  assign sysref_delay_low              = sysref_dly_lo_q;
  assign sysref_delay_high_pulse_count = sysref_dly_hi_q;

  // --------------------------------------------------------------------------
  // Lock detect with holdoff
  // --------------------------------------------------------------------------
  localparam LK_IDLE = 2'h0;
  localparam LK_WAIT = 2'h1;
  localparam LK_LOCK = 2'h2;

  reg [1:0]  lk_state;
  reg [15:0] lk_count;
  wire       use_vtune = lock_indicator_type[`BIT_SRC];
  wire       lock_ok   = ~use_vtune | vtune_ok;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_state    <= LK_IDLE;
      lk_count    <= 16'h0000;
      lock_detect <= 1'b0;
    end else begin
      case (lk_state)
        LK_IDLE: begin
          lock_detect <= 1'b0;
          if (cal_done && !cal_start) begin
            lk_count <= lock_indicator_holdoff;
            if (lock_indicator_holdoff == 16'h0000) begin
              lk_state    <= LK_LOCK;
              lock_detect <= lock_ok;
            end else begin
              lk_state <= LK_WAIT;
            end
          end
        end
        LK_WAIT: begin
          if (cal_start) begin
            lk_state <= LK_IDLE;
          end else if (pd_tick) begin
            if (lk_count == 16'h0001) begin
              lk_state    <= LK_LOCK;
              lock_detect <= lock_ok;
            end
            lk_count <= lk_count - 16'h0001;
          end
        end
        LK_LOCK: begin
          if (cal_start) begin
            lk_state    <= LK_IDLE;
            lock_detect <= 1'b0;
          end else begin
            lock_detect <= lock_ok;
          end
        end
        default: lk_state <= LK_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Modulator reset and divider holdoff
  // --------------------------------------------------------------------------
  // The wait counts phase-detector ticks, so it lengthens sync latency one
  // for one; software must keep it above the loop lock time.
  reg [31:0] mw_count;
  reg        mod_rst_q;
  wire       frac_sync = phase_sync_mode & modulator_reset_n;
  wire       mod_release = modulator_reset_n & ~mod_rst_q;
  wire       sync_done;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Matches the idle-high level of the reset input so that leaving reset
      // is not mistaken for a modulator release.
      mod_rst_q      <= 1'b1;
      modulator_hold <= 1'b1;
      divider_hold   <= 1'b0;
      mw_count       <= 32'h00000000;
    end else begin
      mod_rst_q      <= modulator_reset_n;
      modulator_hold <= ~modulator_reset_n;
      if (!modulator_reset_n) begin
        divider_hold <= phase_sync_mode;
        mw_count     <= 32'h00000000;
      end else if (mod_release && frac_sync) begin
        mw_count     <= modulator_reset_wait;
        divider_hold <= (modulator_reset_wait != 32'h00000000);
      end else if (divider_hold && pd_tick) begin
        if (mw_count <= 32'h00000001) begin
          divider_hold <= 1'b0;
          mw_count     <= 32'h00000000;
        end else begin
          mw_count <= mw_count - 32'h00000001;
        end
      end
    end
  end

  reg div_hold_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_hold_q <= 1'b0;
    end else begin
      div_hold_q <= divider_hold;
    end
  end
  assign sync_done = div_hold_q & ~divider_hold;

  // --------------------------------------------------------------------------
  // Register writes and interrupt status
  // --------------------------------------------------------------------------
  reg        lock_q;
  wire [3:0] events;
  assign events = {bad_code, sync_done, lock_q & ~lock_detect, lock_detect & ~lock_q};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_input_pin_config  <= `RST_SYNC_PIN;
      lock_indicator_type    <= `RST_LOCK_TYPE;
      lock_indicator_holdoff <= `RST_HOLDOFF;
      modulator_reset_wait   <= `RST_MOD_WAIT;
      sysref_ctrl_q          <= `RST_SYSREF_CTRL;
      sysref_divider_q           <= `RST_SYSREF_DIVIDER;
      sysref_dly_lo_q        <= `RST_SYSREF_DLY_LO;
      sysref_dly_hi_q        <= `RST_SYSREF_DLY_HI;
      irq_status             <= 4'h0;
      irq_mask               <= 4'h0;
      lock_q                 <= 1'b0;
    end else begin
      lock_q <= lock_detect;
      if (wr_ok) begin
        case (idx)
          `IDX_SYNC_PIN:      sync_input_pin_config  <= {pwdata[15:9], 9'h001};
          `IDX_LOCK_TYPE:     lock_indicator_type    <= {15'h0000, pwdata[0]};
          `IDX_LOCK_HOLDOFF:  lock_indicator_holdoff <= pwdata[15:0];
          `IDX_MOD_WAIT_HI:   modulator_reset_wait[31:16] <= pwdata[15:0];
          `IDX_MOD_WAIT_LO:   modulator_reset_wait[15:0]  <= pwdata[15:0];
          `IDX_SYSREF_CTRL:   sysref_ctrl_q   <= {8'h00, pwdata[7:2], 2'h1};
          `IDX_SYSREF_DIVIDER:    sysref_divider_q    <= {5'h00, pwdata[10:0]};
          `IDX_SYSREF_DLY_LO: sysref_dly_lo_q <= {4'h0, pwdata[11:0]};
          `IDX_SYSREF_DLY_HI: sysref_dly_hi_q <= pwdata[15:0];
          `IDX_IRQ_MASK:      irq_mask        <= pwdata[3:0];
          default: ;
        endcase
      end
      // A new event wins over a write-one clear in the same cycle.
      if (wr_ok && idx == `IDX_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata[3:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (idx)
        `IDX_SYNC_PIN:      prdata <= {16'h0000, sync_input_pin_config};
        `IDX_LOCK_TYPE:     prdata <= {16'h0000, lock_indicator_type};
        `IDX_LOCK_HOLDOFF:  prdata <= {16'h0000, lock_indicator_holdoff};
        `IDX_MOD_WAIT_HI:   prdata <= {16'h0000, modulator_reset_wait[31:16]};
        `IDX_MOD_WAIT_LO:   prdata <= {16'h0000, modulator_reset_wait[15:0]};
        `IDX_SYSREF_CTRL:   prdata <= {16'h0000, sysref_ctrl_q};
        `IDX_SYSREF_DIVIDER:    prdata <= {16'h0000, sysref_divider_q};
        `IDX_SYSREF_DLY_LO: prdata <= {16'h0000, sysref_dly_lo_q};
        `IDX_SYSREF_DLY_HI: prdata <= {16'h0000, sysref_dly_hi_q};
        `IDX_IRQ_STATUS:    prdata <= {28'h0000000, irq_status};
        `IDX_IRQ_MASK:      prdata <= {28'h0000000, irq_mask};
        `IDX_STATE:         prdata <= {26'h0000000, lk_state, divider_hold,
                                       modulator_hold, lock_detect, bad_code};
        default:            prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// File: tb/pd_tick_source.sv
`timescale 1ns/100ps
// ----------------------------------------
// Phase-detector tick source
// ----------------------------------------
module pd_tick_source #(
  parameter int PERIOD = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      pd_tick
);
  logic [7:0] phase;
  // The divider runs free, so ticks keep coming whether or not the block listens.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 8'h00;
      pd_tick <= 1'b0;
    end else begin
      phase <= (phase == 8'(PERIOD - 1)) ? 8'h00 : phase + 8'h01;
      pd_tick <= (phase == 8'(PERIOD - 1));
    end
  end
endmodule

// File: tb/lock_cfg_sva.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port-level checks
// ----------------------------------------
module lock_cfg_sva (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pd_tick,
  input wire logic       cal_start,
  input wire logic       cal_done,
  input wire logic       vtune_ok,
  input wire logic       phase_sync_mode,
  input wire logic       modulator_reset_n,
  input wire logic       sync_pin,
  input wire logic       sysref_request_pin,
  input wire logic       lock_detect,
  input wire logic       modulator_hold,
  input wire logic       divider_hold,
  input wire logic       sync_gated,
  input wire logic       sysref_request_gated,
  input wire logic       input_high_hysteresis,
  input wire logic [1:0] input_bias_level,
  input wire logic [2:0] input_pin_format
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_sync_gate;
    sync_gated |-> sync_pin && phase_sync_mode;
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync gate open wrongly");
  property p_req_gate;
    sysref_request_gated |-> sysref_request_pin && phase_sync_mode;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request gate open wrongly");
  property p_cfg_hold;
    !(psel && penable && pwrite) |=>
      $stable({input_high_hysteresis, input_bias_level, input_pin_format});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("pin config moved");
  // A rise needs a cause: calibration end, a tick, a register write or a tuning change.
  property p_lock_rise;
    $rose(lock_detect) |-> $past(cal_done | pd_tick | psel) || $past(psel, 2) ||
      ($past(vtune_ok) != $past(vtune_ok, 2));
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose uncaused");
  property p_cal_drop;
    cal_start |=> !lock_detect;
  endproperty
  a_cal_drop: assert property (p_cal_drop) else $error("lock kept over new cal");
  property p_mod_on;
    !modulator_reset_n |=> modulator_hold;
  endproperty
  a_mod_on: assert property (p_mod_on) else $error("modulator not held");
  property p_mod_off;
    modulator_reset_n |=> !modulator_hold;
  endproperty
  a_mod_off: assert property (p_mod_off) else $error("modulator held late");
  property p_div_on;
    !modulator_reset_n && phase_sync_mode |-> ##[1:2] divider_hold;
  endproperty
  a_div_on: assert property (p_div_on) else $error("divider not held");
  property p_div_off;
    $fell(divider_hold) |-> $past(modulator_reset_n);
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider freed in reset");
endmodule

bind sync_lock_detect_config lock_cfg_sva u_lock_cfg_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .pd_tick, .cal_start, .cal_done, .vtune_ok, .phase_sync_mode, .modulator_reset_n,
  .sync_pin, .sysref_request_pin, .lock_detect, .modulator_hold, .divider_hold, .sync_gated,
  .sysref_request_gated, .input_high_hysteresis, .input_bias_level, .input_pin_format);

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        cal_start = 1'b0, cal_done = 1'b0, vtune_ok = 1'b1, phase_sync_mode = 1'b1;
  logic        modulator_reset_n = 1'b1, sync_pin = 1'b1, sysref_request_pin = 1'b1, err;
  wire  [31:0] prdata;
  wire  [2:0]  input_pin_format;
  wire  [1:0]  input_bias_level;
  wire         pready, pslverr, pd_tick, lock_detect, modulator_hold, divider_hold, irq;
  wire         sync_gated, sysref_request_gated, input_high_hysteresis;
  wire  [15:0] s_ctl, s_div, s_dlo, s_dhi;
  int          err_count = 0, n_checks = 0;
  logic [11:0] ra [9] = '{12'h0e8, 12'h0ec, 12'h0f0, 12'h114, 12'h118, 12'h11c, 12'h120,
                          12'h124, 12'h128};
  logic [31:0] rv [9] = '{32'h8001, 32'h0001, 32'h03e8, 32'h0, 32'hc350, 32'h0081, 32'h0,
                          32'h003f, 32'h0};

  sync_lock_detect_config DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pd_tick, .cal_start, .cal_done, .vtune_ok, .phase_sync_mode,
    .modulator_reset_n, .sync_pin, .sysref_request_pin, .lock_detect, .modulator_hold,
    .divider_hold, .sync_gated, .sysref_request_gated, .input_high_hysteresis,
    .input_bias_level, .input_pin_format, .sysref_control(s_ctl), .sysref_divider(s_div),
    .sysref_delay_low(s_dlo), .sysref_delay_high_pulse_count(s_dhi), .irq);
  pd_tick_source #(.PERIOD(4)) far_side (.pclk, .presetn, .pd_tick);

  initial forever #2 pclk = ~pclk;

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  // An idle cycle follows every transfer so psel never falls and rises in one step.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) do @(posedge pclk); while (pd_tick !== 1'b1);
  endtask
  task automatic cal();
    cal_start <= 1'b1;
    @(posedge pclk);
    cal_start <= 1'b0;
    cal_done <= 1'b1;
    @(posedge pclk);
    cal_done <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) rdc(ra[i], rv[i]);
    chk({s_ctl, s_div}, 32'h00810000);
    chk({s_dlo, s_dhi}, 32'h003f0000);
    chk(32'(divider_hold), 32'h0);
    xfer(1'b0, 12'h0f4, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    xfer(1'b1, 12'h184, 32'h8);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 12'h0e8, {16'h0, 1'b1, i[0], i[1:0], i[2:0], 9'h001});
      chk(32'({sync_gated, input_high_hysteresis, input_bias_level, input_pin_format}),
          32'({1'b0, i[0], i[1:0], i[2:0]}));
      xfer(1'b1, 12'h180, 32'hf);
      rdc(12'h180, (i[1:0] == 2'd3 || i[2]) ? 32'h8 : 32'h0);
      chk(32'(irq), (i[1:0] == 2'd3 || i[2]) ? 32'h1 : 32'h0);
    end
    xfer(1'b1, 12'h0e8, 32'h1601);
    xfer(1'b1, 12'h180, 32'hf);
    chk(32'({irq, sync_gated, sysref_request_gated}), 32'h3);
    phase_sync_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'({sync_gated, sysref_request_gated}), 32'h0);
    phase_sync_mode <= 1'b1;
    xfer(1'b1, 12'h0f0, 32'h3);
    cal();
    tick(2);
    chk(32'(lock_detect), 32'h0);
    tick(1);
    repeat (2) @(posedge pclk);
    chk(32'(lock_detect), 32'h1);
    cal_start <= 1'b1;
    @(posedge pclk);
    cal_start <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(lock_detect), 32'h0);
    xfer(1'b1, 12'h0f0, 32'h0);
    cal();
    repeat (2) @(posedge pclk);
    chk(32'(lock_detect), 32'h1);
    vtune_ok <= 1'b0;
    cal();
    repeat (2) @(posedge pclk);
    chk(32'(lock_detect), 32'h0);
    xfer(1'b1, 12'h0ec, 32'h0);
    cal();
    repeat (2) @(posedge pclk);
    chk(32'(lock_detect), 32'h1);
    xfer(1'b1, 12'h114, 32'h0);
    xfer(1'b1, 12'h118, 32'h5);
    xfer(1'b1, 12'h180, 32'hf);
    modulator_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'({modulator_hold, divider_hold}), 32'h3);
    modulator_reset_n <= 1'b1;
    tick(4);
    chk(32'({modulator_hold, divider_hold}), 32'h1);
    tick(2);
    repeat (2) @(posedge pclk);
    chk(32'(divider_hold), 32'h0);
    rdc(12'h180, 32'h4);
    xfer(1'b1, 12'h118, 32'h0);
    modulator_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    modulator_reset_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(divider_hold), 32'h0);
    print_verdict();
  end
endmodule
